// ### rbs_pkg.sv
// Constants, opcodes and register map of the rotate and bank-select unit.
// Assumes one 20 MHz core clock and an external register file that answers reads in the same cycle.
package rbs_pkg;

	localparam int DATA_W = 8;

	// ------------------------------------------------------------
	// Opcodes
	// ------------------------------------------------------------
	localparam logic [7:0] OPC_ROT_L_DIR  = 8'h90;
	localparam logic [7:0] OPC_ROT_L_PTR  = 8'h91;
	localparam logic [7:0] OPC_ROT_LC_DIR = 8'h10;
	localparam logic [7:0] OPC_ROT_LC_PTR = 8'h11;
	localparam logic [7:0] OPC_ROT_R_DIR  = 8'he0;
	localparam logic [7:0] OPC_ROT_R_PTR  = 8'he1;
	localparam logic [7:0] OPC_ROT_RC_DIR = 8'hc0;
	localparam logic [7:0] OPC_ROT_RC_PTR = 8'hc1;
	localparam logic [7:0] OPC_BANK_LO    = 8'h4f;
	localparam logic [7:0] OPC_BANK_HI    = 8'h5f;

	// ------------------------------------------------------------
	// Condition register layout
	// ------------------------------------------------------------
	localparam int FLG_C    = 7;
	localparam int FLG_Z    = 6;
	localparam int FLG_S    = 5;
	localparam int FLG_V    = 4;
	localparam int FLG_BANK = 0;
	localparam int MSB      = 7;
	localparam int LSB      = 0;
	// Opcode bit that picks pointer mode
	localparam int PTR_BIT  = 0;
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [7:0] ZERO_BYTE = 8'h00;

	// ------------------------------------------------------------
	// Software register map
	// ------------------------------------------------------------
	localparam logic [7:0] REG_FLAGS   = 8'h00;
	localparam logic [7:0] REG_STATUS  = 8'h04;
	localparam logic [7:0] REG_OPCODE  = 8'h08;
	localparam logic [7:0] REG_OPERAND = 8'h0c;
	localparam logic [7:0] REG_RESULT  = 8'h10;
	localparam int STS_BUSY    = 0;
	localparam int STS_ILLEGAL = 1;

	// Every instruction here takes four core cycles
	localparam int INSN_CYCLES = 4;

	typedef enum logic [2:0]
	{
		RBS_ROT_L,
		RBS_ROT_LC,
		RBS_ROT_R,
		RBS_ROT_RC,
		RBS_BANK_LO,
		RBS_BANK_HI,
		RBS_ILLEGAL
	} rbs_op_t;

endpackage

// ### rbs_rotator.sv
// One-bit rotate datapath, purely combinational.
// Assumes the caller registers result and carry.
`timescale 1ns/1ns
module rbs_rotator
	import rbs_pkg::*;
(
	// Operation
	input  wire rbs_pkg::rbs_op_t        op,
	input  wire logic [rbs_pkg::DATA_W-1:0] operand,
	input  wire logic                    carry_in,
	// Result
	output logic [rbs_pkg::DATA_W-1:0]   result,
	output logic                         carry_out
);
	import rbs_pkg::*;

	logic [DATA_W-1:1] up;
	logic [DATA_W-2:0] down;
	logic              fill;

	// ------------------------------------------------------------
	// Shifted copies, one generate loop over the inner bits
	// ------------------------------------------------------------
	genvar n;
	generate
		for (n = 0; n < DATA_W - 1; n++)
		begin : g_bit
			assign up[n+1] = operand[n];
			assign down[n] = operand[n+1];
		end
	endgenerate

	// ------------------------------------------------------------
	// End bit and carry
	// ------------------------------------------------------------
	// End bit kept apart so no shifted bit has two drivers
	always_comb
	begin
		fill      = operand[MSB];
		carry_out = carry_in;
		unique case (op)
			RBS_ROT_L:
			begin
				fill      = operand[MSB];
				carry_out = operand[MSB];
			end
			RBS_ROT_LC:
			begin
				fill      = carry_in;
				carry_out = operand[MSB];
			end
			RBS_ROT_R:
			begin
				fill      = operand[LSB];
				carry_out = operand[LSB];
			end
			RBS_ROT_RC:
			begin
				fill      = carry_in;
				carry_out = operand[LSB];
			end
			default:
			begin
				carry_out = carry_in;
			end
		endcase
		if (op == RBS_ROT_L || op == RBS_ROT_LC)
			result = {up, fill};
		else
			result = {fill, down};
	end

endmodule

// ### rbs_unit.sv
// Rotate and bank-select execution unit with its software register port.
// Assumes an external register file that answers a read in the same cycle as rf_rd.
//
// The register offsets and the address-and-strobe port were decided locally.
`timescale 1ns/1ns
module rbs_unit
	import rbs_pkg::*;
(
	// Clock and reset
	input  wire logic                      sys_clk,
	input  wire logic                      rst,
	// Software register port
	input  wire logic [7:0]                addr,
	input  wire logic [rbs_pkg::DATA_W-1:0] wdata,
	input  wire logic                      wr,
	input  wire logic                      rd,
	output logic [rbs_pkg::DATA_W-1:0]     rdata,
	// Register file access
	output logic [7:0]                     rf_addr,
	output logic                           rf_rd,
	input  wire logic [rbs_pkg::DATA_W-1:0] rf_rdata,
	output logic                           rf_we,
	output logic [rbs_pkg::DATA_W-1:0]     rf_wdata,
	// Status
	output logic                           bank_sel,
	output logic                           busy,
	output logic                           done
);
	import rbs_pkg::*;

	typedef enum logic [2:0]
	{
		ST_IDLE,
		ST_ADDR,
		ST_OPND,
		ST_PTR,
		ST_WRITE
	} rbs_state_t;

	rbs_state_t        state;
	rbs_state_t        next_state;
	logic [7:0]        flags;
	logic [7:0]        next_flags;
	logic [7:0]        opcode;
	logic [7:0]        next_opcode;
	logic [7:0]        operand;
	logic [7:0]        next_operand;
	logic [7:0]        result_q;
	logic [7:0]        next_result_q;
	logic [7:0]        value;
	logic [7:0]        next_value;
	logic [7:0]        target;
	logic [7:0]        next_target;
	logic              illegal;
	logic              next_illegal;
	logic [7:0]        next_rdata;
	logic [7:0]        next_rf_addr;
	logic              next_rf_rd;
	logic              next_rf_we;
	logic [7:0]        next_rf_wdata;
	logic              next_busy;
	logic              next_done;
	rbs_op_t           op;
	logic              ptr_mode;
	logic [7:0]        rot_in;
	logic [7:0]        rot_out;
	logic              rot_carry;
	logic              start_wr;
	logic              launch;
	logic              bank_op;

	// ------------------------------------------------------------
	// Opcode decode
	// ------------------------------------------------------------
	always_comb
	begin
		ptr_mode = opcode[PTR_BIT];
		unique case (opcode)
			OPC_ROT_L_DIR, OPC_ROT_L_PTR:   op = RBS_ROT_L;
			OPC_ROT_LC_DIR, OPC_ROT_LC_PTR: op = RBS_ROT_LC;
			OPC_ROT_R_DIR, OPC_ROT_R_PTR:   op = RBS_ROT_R;
			OPC_ROT_RC_DIR, OPC_ROT_RC_PTR: op = RBS_ROT_RC;
			OPC_BANK_LO:                    op = RBS_BANK_LO;
			OPC_BANK_HI:                    op = RBS_BANK_HI;
			default:                        op = RBS_ILLEGAL;
		endcase
	end

	// Pointer mode rotates the byte fetched through the pointer
	assign rot_in = ptr_mode ? rf_rdata : value;

	rbs_rotator u_rot
	(
		.op        (op),
		.operand   (rot_in),
		.carry_in  (flags[FLG_C]),
		.result    (rot_out),
		.carry_out (rot_carry)
	);

	// ------------------------------------------------------------
	// Launch decode
	// ------------------------------------------------------------
	// Opcode and operand writes count only while idle
	assign start_wr = wr && (addr == REG_OPERAND) && (state == ST_IDLE);
	assign launch   = start_wr && (op != RBS_ILLEGAL);
	assign bank_op  = (op == RBS_BANK_LO) || (op == RBS_BANK_HI);

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb
	begin
		next_state   = state;
		next_illegal = illegal;
		next_done    = 1'b0;
		// An illegal opcode is flagged and nothing runs
		if (start_wr)
			next_illegal = (op == RBS_ILLEGAL);
		unique case (state)
			ST_IDLE:
			begin
				if (launch)
					next_state = ST_ADDR;
			end
			ST_ADDR:
			begin
				next_state = ST_OPND;
			end
			ST_OPND:
			begin
				next_state = ST_PTR;
			end
			ST_PTR:
			begin
				// Done rides with the write, inside the fourth cycle
				next_state = ST_WRITE;
				next_done  = 1'b1;
			end
			ST_WRITE:
			begin
				// Fourth and last cycle of every instruction
				next_state = ST_IDLE;
			end
		endcase
		next_busy = (next_state != ST_IDLE);
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			state   <= ST_IDLE;
			illegal <= 1'b0;
			busy    <= 1'b0;
			done    <= 1'b0;
		end
		else
		begin
			state   <= next_state;
			illegal <= next_illegal;
			busy    <= next_busy;
			done    <= next_done;
		end
	end

	// ------------------------------------------------------------
	// Instruction operands
	// ------------------------------------------------------------
	always_comb
	begin
		next_opcode  = opcode;
		next_operand = operand;
		next_value   = value;
		next_target  = target;
		if (wr && (addr == REG_OPCODE) && (state == ST_IDLE))
			next_opcode = wdata;
		// Writing the operand launches the instruction held in opcode
		if (start_wr)
			next_operand = wdata;
		if (launch)
			next_target = wdata;
		if (state == ST_OPND)
		begin
			next_value = rf_rdata;
			// In pointer mode the byte just read names the target
			if (ptr_mode && !bank_op)
				next_target = rf_rdata;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			opcode  <= ZERO_BYTE;
			operand <= ZERO_BYTE;
			value   <= ZERO_BYTE;
			target  <= ZERO_BYTE;
		end
		else
		begin
			opcode  <= next_opcode;
			operand <= next_operand;
			value   <= next_value;
			target  <= next_target;
		end
	end

	// ------------------------------------------------------------
	// Flags and result
	// ------------------------------------------------------------
	always_comb
	begin
		next_flags    = flags;
		next_result_q = result_q;
		if (wr && (addr == REG_FLAGS))
			next_flags = wdata;
		// Execution wins over a software flag write in the same cycle
		if (state == ST_PTR)
		begin
			next_flags = flags;
			if (bank_op)
				next_flags[FLG_BANK] = (op == RBS_BANK_HI);
			else
			begin
				next_result_q     = rot_out;
				next_flags[FLG_C] = rot_carry;
				next_flags[FLG_Z] = (rot_out == ZERO_BYTE);
				next_flags[FLG_S] = rot_out[MSB];
				next_flags[FLG_V] = rot_out[MSB] ^ rot_in[MSB];
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			flags    <= FLAGS_RST;
			result_q <= ZERO_BYTE;
			bank_sel <= 1'b0;
		end
		else
		begin
			flags    <= next_flags;
			result_q <= next_result_q;
			bank_sel <= next_flags[FLG_BANK];
		end
	end

	// ------------------------------------------------------------
	// Register file port
	// ------------------------------------------------------------
	always_comb
	begin
		next_rf_addr  = rf_addr;
		next_rf_rd    = 1'b0;
		next_rf_we    = 1'b0;
		next_rf_wdata = rf_wdata;
		// Bank selection needs no register file access
		if (launch)
		begin
			next_rf_addr = wdata;
			next_rf_rd   = !bank_op;
		end
		// Second read through the pointer; the pointer byte is never written
		if (state == ST_OPND && ptr_mode && !bank_op)
		begin
			next_rf_rd   = 1'b1;
			next_rf_addr = rf_rdata;
		end
		if (state == ST_PTR && !bank_op)
		begin
			next_rf_we    = 1'b1;
			next_rf_addr  = target;
			next_rf_wdata = rot_out;
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
		begin
			rf_addr  <= ZERO_BYTE;
			rf_rd    <= 1'b0;
			rf_we    <= 1'b0;
			rf_wdata <= ZERO_BYTE;
		end
		else
		begin
			rf_addr  <= next_rf_addr;
			rf_rd    <= next_rf_rd;
			rf_we    <= next_rf_we;
			rf_wdata <= next_rf_wdata;
		end
	end

	// ------------------------------------------------------------
	// Read port
	// ------------------------------------------------------------
	always_comb
	begin
		next_rdata = ZERO_BYTE;
		if (rd)
		begin
			unique case (addr)
				REG_FLAGS:   next_rdata = flags;
				REG_STATUS:
				begin
					next_rdata              = ZERO_BYTE;
					next_rdata[STS_BUSY]    = busy;
					next_rdata[STS_ILLEGAL] = illegal;
				end
				REG_OPCODE:  next_rdata = opcode;
				REG_OPERAND: next_rdata = operand;
				REG_RESULT:  next_rdata = result_q;
				default:     next_rdata = ZERO_BYTE;
			endcase
		end
	end

	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			rdata <= ZERO_BYTE;
		else
			rdata <= next_rdata;
	end

endmodule

// ### rbs_props.sv
// Checker for rbs_unit timing and flag rules.
// Assumes the opcode is written before the operand.
`timescale 1ns/1ns
module rbs_props
	import rbs_pkg::*;
(
	// Port copies
	input wire logic       sys_clk,
	input wire logic       rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rf_rd,
	input wire logic       rf_we,
	input wire logic       bank_sel,
	input wire logic       busy,
	input wire logic       done
);
	logic [7:0] opc;
	logic [7:0] next_opc;
	logic       launch;
	logic       bank_op;
	// ----------------------------------------
	// Opcode shadow
	// ----------------------------------------
	always_comb
	begin
		next_opc = opc;
		if (wr && addr == REG_OPCODE && !busy)
			next_opc = wdata;
	end
	always_ff @(posedge sys_clk or posedge rst)
	begin
		if (rst)
			opc <= 8'h00;
		else
			opc <= next_opc;
	end
	assign bank_op = opc == OPC_BANK_LO || opc == OPC_BANK_HI;
	assign launch = wr && addr == REG_OPERAND && !busy && (bank_op || opc inside
		{8'h90, 8'h91, 8'h10, 8'h11, 8'he0, 8'he1, 8'hc0, 8'hc1});
	// ----------------------------------------
	// Properties
	// ----------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	sequence launch_s;
		launch;
	endsequence
	sequence run_s;
		busy [*4];
	endsequence
	chk_busy_run: assert property (launch_s |=> run_s)
		else $error("busy not held for the instruction");
	chk_done_time: assert property (launch_s |-> ##4 done)
		else $error("done not four cycles after launch");
	chk_done_pulse: assert property (done |=> !done)
		else $error("done longer than one cycle");
	chk_write_done: assert property (rf_we |-> done)
		else $error("register write outside the last cycle");
	chk_rot_write: assert property (launch_s ##0 !bank_op |-> ##4 rf_we)
		else $error("rotate result not written");
	chk_bank_hi: assert property (launch && opc == OPC_BANK_HI |-> ##5 bank_sel)
		else $error("upper bank not selected");
	chk_bank_lo: assert property (launch && opc == OPC_BANK_LO |-> ##5 !bank_sel)
		else $error("lower bank not selected");
	chk_bank_nowrite: assert property (launch && bank_op |-> ##4 !rf_we)
		else $error("bank select wrote a register");
	chk_read_busy: assert property (rf_rd |-> busy)
		else $error("register file read while idle");
endmodule
bind rbs_unit rbs_props rbs_props_inst (.sys_clk(sys_clk), .rst(rst), .addr(addr),
	.wdata(wdata), .wr(wr), .rf_rd(rf_rd), .rf_we(rf_we), .bank_sel(bank_sel),
	.busy(busy), .done(done));

// ### testbench.sv
// Self-checking bench for rbs_unit.
// Assumes the register file answers the address on rf_addr at once.
`timescale 1ns/1ns
module testbench;
	import rbs_pkg::*;
	logic       sys_clk;
	logic       rst;
	logic [7:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;
	logic [7:0] rf_addr;
	logic       rf_rd;
	logic [7:0] rf_rdata;
	logic       rf_we;
	logic [7:0] rf_wdata;
	logic       bank_sel;
	logic       busy;
	logic       done;
	logic [7:0] mem [256];
	logic [7:0] got;
	int         n_fail;
	int         total_checks;

	rbs_unit rbs_unit_inst (.sys_clk(sys_clk), .rst(rst), .addr(addr), .wdata(wdata),
		.wr(wr), .rd(rd), .rdata(rdata), .rf_addr(rf_addr), .rf_rd(rf_rd),
		.rf_rdata(rf_rdata), .rf_we(rf_we), .rf_wdata(rf_wdata), .bank_sel(bank_sel),
		.busy(busy), .done(done));
	// ----------------------------------------
	// Register file model
	// ----------------------------------------
	assign rf_rdata = mem[rf_addr];
	always @(posedge sys_clk)
		if (rf_we)
			mem[rf_addr] <= rf_wdata;
	// ----------------------------------------
	// Tasks
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic finish_test;
		if (n_fail == 0 && total_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge sys_clk);
		wr <= 1'b0;
	endtask
	task automatic rd_reg(input logic [7:0] a);
		@(posedge sys_clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge sys_clk);
		rd <= 1'b0;
		#1 got = rdata;
	endtask
	task automatic wait_done;
		int n;
		n = 0;
		while (done !== 1'b1 && n < 20)
		begin
			@(posedge sys_clk);
			#1 n++;
		end
		check({7'h00, done}, 8'h01);
		repeat (2) @(posedge sys_clk);
	endtask
	task automatic run_op(input logic [7:0] opc, input logic [7:0] r);
		wr_reg(REG_OPCODE, opc);
		wr_reg(REG_OPERAND, r);
		wait_done();
	endtask
	task automatic t_regs;
		mem[8'h20] = 8'h81;
		rd_reg(8'hfc);
		check(got, 8'h00);
		wr_reg(REG_OPCODE, 8'h00);
		wr_reg(REG_OPERAND, 8'h20);
		repeat (6) @(posedge sys_clk);
		rd_reg(REG_STATUS);
		check(got, 8'h02);
		wr_reg(REG_OPCODE, OPC_ROT_R_DIR);
		wr_reg(REG_OPERAND, 8'h20);
		wr_reg(REG_OPCODE, OPC_BANK_HI);
		wait_done();
		rd_reg(REG_OPCODE);
		check(got, OPC_ROT_R_DIR);
		check(mem[8'h20], 8'hc0);
		rd_reg(REG_STATUS);
		check(got, 8'h00);
	endtask
	task automatic t_rotates;
		logic [7:0] opc;
		logic [7:0] d;
		logic [7:0] res;
		logic       cin;
		logic       cout;
		for (int k = 0; k < 16; k++)
		begin
			opc = k[2:1] == 0 ? OPC_ROT_L_DIR : k[2:1] == 1 ? OPC_ROT_LC_DIR :
				k[2:1] == 2 ? OPC_ROT_R_DIR : OPC_ROT_RC_DIR;
			opc = opc | {7'h00, k[0]};
			d = k[3] ? 8'h00 : 8'ha5 ^ 8'(k * 29);
			cin = k[3] ? 1'b0 : ~k[0];
			case (k[2:1])
				0: {cout, res} = {d[7], d[6:0], d[7]};
				1: {cout, res} = {d[7], d[6:0], cin};
				2: {cout, res} = {d[0], d[0], d[7:1]};
				default: {cout, res} = {d[0], cin, d[7:1]};
			endcase
			mem[8'h20] = k[0] ? 8'h30 : d;
			mem[8'h30] = d;
			wr_reg(REG_FLAGS, {cin, 7'h0c});
			run_op(opc, 8'h20);
			check(mem[k[0] ? 8'h30 : 8'h20], res);
			check(mem[8'h20], k[0] ? 8'h30 : res);
			rd_reg(REG_FLAGS);
			check(got, {cout, res == 8'h00, res[7], res[7] ^ d[7], 4'hc});
			rd_reg(REG_RESULT);
			check(got, res);
		end
	endtask
	task automatic t_bank;
		wr_reg(REG_FLAGS, 8'hfe);
		run_op(OPC_BANK_HI, 8'h00);
		rd_reg(REG_FLAGS);
		check(got, 8'hff);
		check({7'h00, bank_sel}, 8'h01);
		run_op(OPC_BANK_LO, 8'h00);
		rd_reg(REG_FLAGS);
		check(got, 8'hfe);
		check({7'h00, bank_sel}, 8'h00);
	endtask
	// ----------------------------------------
	// Clock, sequence and watchdog
	// ----------------------------------------
	initial
	begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	initial
	begin
		#200000;
		n_fail++;
		finish_test();
	end
	initial
	begin
		rst = 1'b1;
		addr = 8'h00;
		wdata = 8'h00;
		wr = 1'b0;
		rd = 1'b0;
		n_fail = 0;
		total_checks = 0;
		foreach (mem[i])
			mem[i] = 8'h00;
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		t_regs();
		t_rotates();
		t_bank();
		finish_test();
	end
endmodule
